// ===== hdl/mac_serial_device.sv
// Baseband end of the serial data port
`timescale 1ns/1ns
module mac_serial_device (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Link to controller
    serial_port_if.device link,
    // Modem transmit side
    input wire serial_port_pkg::rate_t txRate,
    input wire logic headerDone,
    output logic txRunning,
    output logic txPayloadBit,
    output logic txPayloadValid,
    // Modem receive side
    input wire serial_port_pkg::rate_t rxRate,
    input wire logic delimiterSeen,
    input wire logic headerError,
    input wire logic crcHold,
    input wire logic rxBitIn,
    output logic rxBitTake,
    output logic rxRunning,
    // Configuration and detectors
    input wire logic txEdgeInvert,
    input wire logic rxClockInvert,
    input wire logic ccaInvert,
    input wire serial_port_pkg::cca_mode_t ccaMode,
    input wire logic energyBusy,
    input wire logic carrierBusy,
    input wire logic diversityOn,
    input wire logic antennaSwitch
);
    import serial_port_pkg::*;

    function automatic logic [DIV_W-1:0] halfDiv(input rate_t rate);
        case (rate)
            RATE_CODE0: halfDiv = HALF_RATE0;
            RATE_CODE1: halfDiv = HALF_RATE1;
            RATE_CODE2: halfDiv = HALF_RATE2;
            default: halfDiv = HALF_RATE3;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic txPeMeta_q, txPeSync_q, txPePrev_q;
    logic rxPeMeta_q, rxPeSync_q;
    logic txdMeta_q, txdSync_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            txPeMeta_q <= 1'b0;
            txPeSync_q <= 1'b0;
            txPePrev_q <= 1'b0;
            rxPeMeta_q <= 1'b0;
            rxPeSync_q <= 1'b0;
            txdMeta_q <= 1'b0;
            txdSync_q <= 1'b0;
        end else begin
            txPeMeta_q <= link.txPathEnable;
            txPeSync_q <= txPeMeta_q;
            txPePrev_q <= txPeSync_q;
            rxPeMeta_q <= link.rxPathEnable;
            rxPeSync_q <= rxPeMeta_q;
            txdMeta_q <= link.txSerialData;
            txdSync_q <= txdMeta_q;
        end
    end

    // ------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------
    logic cfgTxEdge_q, cfgRxInv_q, cfgCcaInv_q;
    cca_mode_t cfgCcaMode_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            cfgTxEdge_q <= CFG_TX_EDGE_RST;
            cfgRxInv_q <= CFG_RX_INV_RST;
            cfgCcaInv_q <= CFG_CCA_INV_RST;
            cfgCcaMode_q <= CFG_CCA_MODE_RST;
        end else begin
            cfgTxEdge_q <= txEdgeInvert;
            cfgRxInv_q <= rxClockInvert;
            cfgCcaInv_q <= ccaInvert;
            cfgCcaMode_q <= ccaMode;
        end
    end

    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------
    tx_state_e txState_q, txState_d;
    logic [RAMP_CNT_W-1:0] rampCnt_q, rampCnt_d;
    rate_t txRate_q, txRate_d;
    logic [DIV_W-1:0] txDiv_q, txDiv_d;
    logic tx_bit_clock_q, tx_bit_clock_d;
    logic [1:0] sampleDly_q, sampleDly_d;
    logic txBit_q, txBit_d, txValid_q, txValid_d;
    logic peRise, peFall, txToggle, sampleNow;

    always_comb begin
        peRise = txPeSync_q & ~txPePrev_q;
        peFall = ~txPeSync_q & txPePrev_q;
        txState_d = txState_q;
        rampCnt_d = '0;
        case (txState_q)
            TX_IDLE: begin
                if (peRise) begin
                    txState_d = TX_HEADER;
                end
            end
            TX_HEADER: begin
                if (peFall) begin
                    txState_d = TX_RAMP;
                end else if (headerDone) begin
                    txState_d = TX_PAYLOAD;
                end
            end
            TX_PAYLOAD: begin
                if (peFall) begin
                    txState_d = TX_RAMP;
                end
            end
            TX_RAMP: begin
                rampCnt_d = rampCnt_q + 7'h01;
                if (peRise) begin
                    txState_d = TX_HEADER;
                end else if (rampCnt_q == RAMP_LAST) begin
                    txState_d = TX_IDLE;
                end
            end
            default: txState_d = TX_IDLE;
        endcase
        txRate_d = peRise ? txRate : txRate_q;
        txToggle = (txDiv_q >= DIV_W'(halfDiv(txRate_q) - 4'h1));
        txDiv_d = txToggle ? '0 : txDiv_q + 4'h1;
        tx_bit_clock_d = txToggle ? ~tx_bit_clock_q : tx_bit_clock_q;
        sampleNow = txToggle & (cfgTxEdge_q ? tx_bit_clock_q : ~tx_bit_clock_q);
        sampleDly_d = {sampleDly_q[0], sampleNow};
        txBit_d = txBit_q;
        txValid_d = 1'b0;
        if (sampleDly_q[1] && (txState_q == TX_PAYLOAD ||
                txState_q == TX_RAMP)) begin
            txBit_d = txdSync_q;
            txValid_d = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            txState_q <= TX_IDLE;
            rampCnt_q <= '0;
            txRate_q <= RATE_RST;
            txDiv_q <= '0;
            tx_bit_clock_q <= 1'b0;
            sampleDly_q <= '0;
            txBit_q <= 1'b0;
            txValid_q <= 1'b0;
        end else begin
            txState_q <= txState_d;
            rampCnt_q <= rampCnt_d;
            txRate_q <= txRate_d;
            txDiv_q <= txDiv_d;
            tx_bit_clock_q <= tx_bit_clock_d;
            sampleDly_q <= sampleDly_d;
            txBit_q <= txBit_d;
            txValid_q <= txValid_d;
        end
    end

    assign txRunning = (txState_q != TX_IDLE);
    assign txPayloadBit = txBit_q;
    assign txPayloadValid = txValid_q;
    assign link.txBitClock = tx_bit_clock_q;
    assign link.txReady = (txState_q == TX_PAYLOAD);

    // ------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------
    rx_state_e rxState_q, rxState_d;
    logic [DIV_W-1:0] rxDiv_q, rxDiv_d;
    logic rx_bit_clock_q, rx_bit_clock_d, rxClkOut_q, rxClkOut_d;
    logic rxData_q, rxData_d;
    logic rxToggle;

    always_comb begin
        rxToggle = (rxDiv_q == DIV_W'(halfDiv(rxRate) - 4'h1));
        rxState_d = rxState_q;
        rxDiv_d = '0;
        rx_bit_clock_d = 1'b0;
        rxData_d = rxData_q;
        rxBitTake = 1'b0;
        case (rxState_q)
            RX_IDLE: begin
                if (rxPeSync_q && delimiterSeen) begin
                    rxState_d = RX_DELIVER;
                    rxData_d = rxBitIn;
                    rxBitTake = 1'b1;
                end
            end
            RX_DELIVER: begin
                if (!rxPeSync_q || headerError) begin
                    rxState_d = RX_IDLE;
                end else if (!crcHold) begin
                    rxDiv_d = rxToggle ? '0 : rxDiv_q + 4'h1;
                    rx_bit_clock_d = rxToggle ? ~rx_bit_clock_q : rx_bit_clock_q;
                    if (rxToggle && rx_bit_clock_q) begin
                        rxData_d = rxBitIn;
                        rxBitTake = 1'b1;
                    end
                end
            end
            default: rxState_d = RX_IDLE;
        endcase
        rxClkOut_d = rx_bit_clock_d ^ cfgRxInv_q;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rxState_q <= RX_IDLE;
            rxDiv_q <= '0;
            rx_bit_clock_q <= 1'b0;
            rxClkOut_q <= 1'b0;
            rxData_q <= 1'b0;
        end else begin
            rxState_q <= rxState_d;
            rxDiv_q <= rxDiv_d;
            rx_bit_clock_q <= rx_bit_clock_d;
            rxClkOut_q <= rxClkOut_d;
            rxData_q <= rxData_d;
        end
    end

    assign rxRunning = rxPeSync_q;
    assign link.rxBitClock = rxClkOut_q;
    assign link.rxSerialData = rxData_q;
    assign link.headerValidStrobe = (rxState_q == RX_DELIVER);

    // ------------------------------------------------------------
    // Channel flag and antenna select
    // ------------------------------------------------------------
    logic ccaBusy, cca_q, cca_d;
    logic antenna_select_q, antenna_select_d, antSelN_q, antSelN_d;

    always_comb begin
        case (cfgCcaMode_q)
            CCA_ENERGY: ccaBusy = energyBusy;
            CCA_CARRIER: ccaBusy = carrierBusy;
            CCA_EITHER: ccaBusy = energyBusy | carrierBusy;
            default: ccaBusy = energyBusy & carrierBusy;
        endcase
        cca_d = ccaBusy ^ cfgCcaInv_q;
        antenna_select_d = (diversityOn && antennaSwitch) ? ~antenna_select_q : antenna_select_q;
        antSelN_d = ~antenna_select_d;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            cca_q <= 1'b0;
            antenna_select_q <= ANT_SEL_RST;
            antSelN_q <= ~ANT_SEL_RST;
        end else begin
            cca_q <= cca_d;
            antenna_select_q <= antenna_select_d;
            antSelN_q <= antSelN_d;
        end
    end

    assign link.channelClearFlag = cca_q;
    assign link.antennaSelect = antenna_select_q;
    assign link.antennaSelectN = antSelN_q;
endmodule

// ===== hdl/mac_serial_host.sv
// Controller end of the serial data port
`timescale 1ns/1ns
module mac_serial_host (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Link to device
    serial_port_if.host link,
    // User transmit side
    input wire logic txStart,
    input wire logic [7:0] txByte,
    input wire logic txLast,
    input wire logic txByteValid,
    output logic txByteReady,
    output logic txBusy,
    // User receive side
    input wire logic rxEnable,
    output logic [7:0] rxByte,
    output logic rxByteValid,
    output logic frameActive,
    output logic channelBusy,
    // Configuration
    input wire logic txEdgeInvert,
    input wire logic rxClockInvert,
    input wire logic ccaInvert
);
    import serial_port_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic rdyM_q, rdyS_q, ackM_q, ackS_q, finM_q, finS_q;
    logic rclkM_q, rclkS_q, rxdM_q, rxdS_q, strM_q, strS_q;
    logic ccaM_q, ccaS_q;
    logic ackT_q, final_q, lrM_q, lrS_q;
    logic launchRst_q, launchRst_d, lrAckM_q, lrAckS_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            {rdyM_q, rdyS_q, ackM_q, ackS_q, finM_q, finS_q} <= '0;
            {rclkM_q, rclkS_q, rxdM_q, rxdS_q, strM_q, strS_q} <= '0;
            {ccaM_q, ccaS_q} <= '0;
            launchRst_q <= 1'b1;
            {lrAckM_q, lrAckS_q} <= '0;
        end else begin
            launchRst_q <= launchRst_d;
            {lrAckS_q, lrAckM_q} <= {lrAckM_q, lrS_q};
            {rdyS_q, rdyM_q} <= {rdyM_q, link.txReady};
            {ackS_q, ackM_q} <= {ackM_q, ackT_q};
            {finS_q, finM_q} <= {finM_q, final_q};
            {rclkS_q, rclkM_q} <= {rclkM_q, link.rxBitClock};
            {rxdS_q, rxdM_q} <= {rxdM_q, link.rxSerialData};
            {strS_q, strM_q} <= {strM_q, link.headerValidStrobe};
            {ccaS_q, ccaM_q} <= {ccaM_q, link.channelClearFlag};
        end
    end

    // Launch side reset held until it echoes back
    always_comb begin
        launchRst_d = launchRst_q;
        if (lrAckS_q) begin
            launchRst_d = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Transmit sequencing
    // ------------------------------------------------------------
    host_tx_e ht_q, ht_d;
    logic reqT_q, reqT_d, holdLast_q, holdLast_d;
    logic [BYTE_W-1:0] hold_q, hold_d;
    logic accept;

    always_comb begin
        txByteReady = (ht_q == HT_SEND) && (reqT_q == ackS_q);
        accept = txByteValid & txByteReady;
        ht_d = ht_q;
        reqT_d = reqT_q;
        hold_d = hold_q;
        holdLast_d = holdLast_q;
        case (ht_q)
            HT_IDLE: if (txStart) ht_d = HT_WAIT;
            HT_WAIT: if (rdyS_q) ht_d = HT_SEND;
            HT_SEND: begin
                if (accept) begin
                    hold_d = txByte;
                    holdLast_d = txLast;
                    reqT_d = ~reqT_q;
                    if (txLast) begin
                        ht_d = HT_END;
                    end
                end
            end
            HT_END: if (finS_q) ht_d = HT_IDLE;
            default: ht_d = HT_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ht_q <= HT_IDLE;
            reqT_q <= 1'b0;
            hold_q <= '0;
            holdLast_q <= 1'b0;
        end else begin
            ht_q <= ht_d;
            reqT_q <= reqT_d;
            hold_q <= hold_d;
            holdLast_q <= holdLast_d;
        end
    end

    assign txBusy = (ht_q != HT_IDLE);
    assign link.txPathEnable = txBusy;

    // ------------------------------------------------------------
    // Transmit shifter on the launch edge of the bit clock
    // ------------------------------------------------------------
    logic launchClk, reqM_q, reqS_q;
    logic full_q, full_d, last_q, last_d, txd_q, txd_d, ackT_d, final_d;
    logic [BYTE_W-1:0] shift_q, shift_d;
    logic [BIT_CNT_W-1:0] cnt_q, cnt_d;

    assign launchClk = txEdgeInvert ? link.txBitClock : ~link.txBitClock;

    always_ff @(posedge launchClk) begin
        lrM_q <= launchRst_q;
        lrS_q <= lrM_q;
    end

    always_comb begin
        full_d = full_q;
        last_d = last_q;
        shift_d = shift_q;
        cnt_d = cnt_q;
        ackT_d = ackT_q;
        txd_d = 1'b0;
        if ((reqS_q != ackT_q) && (!full_q || cnt_q == '0)) begin
            txd_d = hold_q[0];
            shift_d = {1'b0, hold_q[BYTE_W-1:1]};
            cnt_d = 3'h1;
            full_d = 1'b1;
            last_d = holdLast_q;
            ackT_d = ~ackT_q;
        end else if (full_q && cnt_q != '0) begin
            txd_d = shift_q[0];
            shift_d = {1'b0, shift_q[BYTE_W-1:1]};
            cnt_d = cnt_q + 3'h1;
        end else begin
            full_d = 1'b0;
        end
        final_d = full_q & last_q & (cnt_q == FINAL_MARK_IDX);
    end

    always_ff @(posedge launchClk) begin
        if (lrS_q) begin
            reqM_q <= 1'b0;
            reqS_q <= 1'b0;
            {full_q, last_q, txd_q, ackT_q, final_q} <= '0;
            shift_q <= '0;
            cnt_q <= '0;
        end else begin
            reqM_q <= reqT_q;
            reqS_q <= reqM_q;
            full_q <= full_d;
            last_q <= last_d;
            txd_q <= txd_d;
            ackT_q <= ackT_d;
            final_q <= final_d;
            shift_q <= shift_d;
            cnt_q <= cnt_d;
        end
    end

    assign link.txSerialData = txd_q;

    // ------------------------------------------------------------
    // Receive capture
    // ------------------------------------------------------------
    logic clkLvl, clkPrev_q, rise, rxValid_q, rxValid_d, rxPe_q, busy_q;
    logic [BYTE_W-1:0] rxShift_q, rxShift_d, rxByte_q, rxByte_d;
    logic [BIT_CNT_W-1:0] rxCnt_q, rxCnt_d;

    always_comb begin
        clkLvl = rclkS_q ^ rxClockInvert;
        rise = clkLvl & ~clkPrev_q;
        rxShift_d = rxShift_q;
        rxCnt_d = rxCnt_q;
        rxByte_d = rxByte_q;
        rxValid_d = 1'b0;
        if (!strS_q) begin
            rxCnt_d = '0;
        end else if (rise) begin
            rxShift_d = {rxdS_q, rxShift_q[BYTE_W-1:1]};
            rxCnt_d = rxCnt_q + 3'h1;
            if (rxCnt_q == LAST_BIT_IDX) begin
                rxByte_d = rxShift_d;
                rxValid_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            clkPrev_q <= 1'b0;
            rxShift_q <= '0;
            rxCnt_q <= '0;
            rxByte_q <= '0;
            rxValid_q <= 1'b0;
            rxPe_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            clkPrev_q <= clkLvl;
            rxShift_q <= rxShift_d;
            rxCnt_q <= rxCnt_d;
            rxByte_q <= rxByte_d;
            rxValid_q <= rxValid_d;
            rxPe_q <= rxEnable;
            busy_q <= ccaS_q ^ ccaInvert;
        end
    end

    assign rxByte = rxByte_q;
    assign rxByteValid = rxValid_q;
    assign frameActive = strS_q;
    assign channelBusy = busy_q;
    assign link.rxPathEnable = rxPe_q;
endmodule

// ===== hdl/serial_port_if.sv
// Link wires between the baseband device and its controller
`timescale 1ns/1ns
interface serial_port_if;
    logic antennaSelect;
    logic antennaSelectN;
    logic txPathEnable;
    logic txBitClock;
    logic txReady;
    logic txSerialData;
    logic channelClearFlag;
    logic rxSerialData;
    logic rxBitClock;
    logic headerValidStrobe;
    logic rxPathEnable;

    modport device (
        output antennaSelect, antennaSelectN, txBitClock, txReady,
        output channelClearFlag, rxSerialData, rxBitClock,
        output headerValidStrobe,
        input txPathEnable, txSerialData, rxPathEnable
    );
    modport host (
        input antennaSelect, antennaSelectN, txBitClock, txReady,
        input channelClearFlag, rxSerialData, rxBitClock,
        input headerValidStrobe,
        output txPathEnable, txSerialData, rxPathEnable
    );
endinterface

// ===== hdl/serial_port_pkg.sv
// Shared constants and types for the serial data port
package serial_port_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int RAMP_TIME_NS = 4000;
    localparam int RAMP_CYCLES =
        (RAMP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int RAMP_CNT_W = 7;
    localparam logic [RAMP_CNT_W-1:0] RAMP_LAST =
        RAMP_CNT_W'(RAMP_CYCLES - 1);

    // ------------------------------------------------------------
    // Bit clock dividers, half period in clock cycles per rate code
    // ------------------------------------------------------------
    localparam int DIV_W = 4;
    localparam logic [DIV_W-1:0] HALF_RATE0 = 4'ha;
    localparam logic [DIV_W-1:0] HALF_RATE1 = 4'h5;
    localparam logic [DIV_W-1:0] HALF_RATE2 = 4'h4;
    localparam logic [DIV_W-1:0] HALF_RATE3 = 4'h3;
    localparam logic [1:0] RATE_CODE0 = 2'h0;
    localparam logic [1:0] RATE_CODE1 = 2'h1;
    localparam logic [1:0] RATE_CODE2 = 2'h2;
    typedef logic [1:0] rate_t;

    // ------------------------------------------------------------
    // Channel assessment modes
    // ------------------------------------------------------------
    localparam logic [1:0] CCA_ENERGY = 2'h0;
    localparam logic [1:0] CCA_CARRIER = 2'h1;
    localparam logic [1:0] CCA_EITHER = 2'h2;
    typedef logic [1:0] cca_mode_t;

    // ------------------------------------------------------------
    // Reset values and byte framing
    // ------------------------------------------------------------
    localparam logic CFG_TX_EDGE_RST = 1'b0;
    localparam logic CFG_RX_INV_RST = 1'b0;
    localparam logic CFG_CCA_INV_RST = 1'b0;
    localparam cca_mode_t CFG_CCA_MODE_RST = 2'h0;
    localparam rate_t RATE_RST = 2'h0;
    localparam logic ANT_SEL_RST = 1'b0;
    localparam int BYTE_W = 8;
    localparam int BIT_CNT_W = 3;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT_IDX = 3'h7;
    localparam logic [BIT_CNT_W-1:0] FINAL_MARK_IDX = 3'h6;

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {TX_IDLE, TX_HEADER, TX_PAYLOAD, TX_RAMP}
        tx_state_e;
    typedef enum logic {RX_IDLE, RX_DELIVER} rx_state_e;
    typedef enum logic [1:0] {HT_IDLE, HT_WAIT, HT_SEND, HT_END}
        host_tx_e;
endpackage

// ===== tb/mac_serial_data_port_assertions.sv
// Link assertions for the serial data port
`timescale 1ns/1ns
module mac_serial_data_port_assertions (
    // Device clock and reset
    input wire logic clock,
    input wire logic srst,
    // Link
    input wire logic antennaSelect,
    input wire logic antennaSelectN,
    input wire logic txPathEnable,
    input wire logic txBitClock,
    input wire logic txReady,
    input wire logic rxSerialData,
    input wire logic rxBitClock,
    input wire logic headerValidStrobe,
    input wire logic rxPathEnable
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    property p_ant; antennaSelect != antennaSelectN; endproperty
    a_ant: assert property (p_ant)
        else $error("antenna outputs equal");
    property p_rdyOn; $rose(txReady) |-> txPathEnable; endproperty
    a_rdyOn: assert property (p_rdyOn)
        else $error("ready without enable");
    property p_rdyOff; $fell(txPathEnable) |-> ##[1:5] !txReady; endproperty
    a_rdyOff: assert property (p_rdyOff)
        else $error("ready stuck after enable fall");
    property p_hvOff;
        $fell(rxPathEnable) |-> ##[1:5] !headerValidStrobe;
    endproperty
    a_hvOff: assert property (p_hvOff)
        else $error("strobe stuck after disable");
    property p_idle; !headerValidStrobe [*3] |-> $stable(rxBitClock); endproperty
    a_idle: assert property (p_idle)
        else $error("rx clock moves outside frame");
    property p_first; $rose(headerValidStrobe) |-> !rxBitClock [*3]; endproperty
    a_first: assert property (p_first)
        else $error("rx clock not low at frame start");
    property p_rxData; $rose(rxBitClock) |-> $stable(rxSerialData); endproperty
    a_rxData: assert property (p_rxData)
        else $error("rx data moves at sampling edge");
    property p_tx_bit_clock; !txBitClock |-> ##[1:12] txBitClock; endproperty
    a_tx_bit_clock: assert property (p_tx_bit_clock)
        else $error("tx clock stalled");
endmodule

// ===== tb/mac_serial_data_port_bench.sv
// Bench joining both ends of the serial data port
`timescale 1ns/1ns
module mac_serial_data_port_bench;
    import serial_port_pkg::*;
    logic clock = 1'h0, devClock = 1'h0, srst = 1'h1;
    logic txStart = 1'h0, txLast = 1'h0, txByteValid = 1'h0;
    logic rxEnable = 1'h0, headerDone = 1'h0, delimiterSeen = 1'h0;
    logic headerError = 1'h0, crcHold = 1'h0, energyBusy = 1'h1;
    logic carrierBusy = 1'h0, diversityOn = 1'h1, antennaSwitch = 1'h0;
    logic ccaInvert = 1'h0, txEdgeInvert = 1'h0, rxClockInvert = 1'h0;
    logic txByteReady, txBusy, rxByteValid, frameActive, channelBusy;
    logic txRunning, txPayloadBit, txPayloadValid, rxBitTake, rxRunning;
    logic rxBitIn;
    logic [7:0] txByte = 8'h0, rxByte, rxPat = 8'h0;
    logic [15:0] txGot = 16'h0;
    logic [2:0] rxIdx = 3'h0;
    rate_t txRate = 2'h1, rxRate = 2'h0;
    cca_mode_t ccaMode = 2'h0;
    int error_cnt = 0, samples_checked = 0, nTx = 0, n = 0;
    always #25 clock = ~clock;
    always #24 devClock = ~devClock;
    serial_port_if link();
    mac_serial_device u_mac_serial_device (.clock(devClock), .srst,
        .link(link.device), .txRate, .headerDone, .txRunning,
        .txPayloadBit, .txPayloadValid, .rxRate, .delimiterSeen,
        .headerError, .crcHold, .rxBitIn, .rxBitTake, .rxRunning,
        .txEdgeInvert, .rxClockInvert, .ccaInvert, .ccaMode, .energyBusy,
        .carrierBusy, .diversityOn, .antennaSwitch);
    mac_serial_host u_mac_serial_host (.clock, .srst, .link(link.host),
        .txStart, .txByte, .txLast, .txByteValid, .txByteReady, .txBusy,
        .rxEnable, .rxByte, .rxByteValid, .frameActive, .channelBusy,
        .txEdgeInvert, .rxClockInvert, .ccaInvert);
    mac_serial_data_port_assertions u_mac_serial_data_port_assertions (
        .clock(devClock), .srst, .antennaSelect(link.antennaSelect),
        .antennaSelectN(link.antennaSelectN), .txReady(link.txReady),
        .txPathEnable(link.txPathEnable), .txBitClock(link.txBitClock),
        .rxSerialData(link.rxSerialData), .rxBitClock(link.rxBitClock),
        .headerValidStrobe(link.headerValidStrobe),
        .rxPathEnable(link.rxPathEnable));
    assign rxBitIn = rxPat[rxIdx];
    // Modem side stand-in: header done at once, bits captured and fed
    always @(posedge devClock) begin
        headerDone <= txRunning;
        if (rxEnable !== 1'h1) rxIdx <= 3'h0;
        else if (rxBitTake === 1'h1) rxIdx <= rxIdx + 3'h1;
        if (txPayloadValid === 1'h1 && nTx < 16 &&
                (nTx > 0 || txPayloadBit === 1'h1)) begin
            txGot[nTx] <= txPayloadBit;
            nTx <= nTx + 1;
        end
    end
    task automatic hc(input int k);
        repeat (k) @(posedge clock);
        #2;
    endtask
    task automatic dc(input int k);
        repeat (k) @(posedge devClock);
        #2;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic guard(input logic hung);
        if (hung) begin
            error_cnt++;
            $display("[FAIL] %0t wait ran out", $time);
            conclude();
        end
    endtask
    task automatic putByte(input logic [7:0] b, input logic last);
        txByte = b;
        txLast = last;
        txByteValid = 1'h1;
        n = 0;
        while (txByteReady !== 1'h1 && n++ < 3000) hc(1);
        guard(n > 3000);
        hc(1);
        txByteValid = 1'h0;
        hc(1);
    endtask
    task automatic getByte(input logic [7:0] b, input logic viaError);
        rxPat = b;
        rxEnable = 1'h1;
        dc(6);
        delimiterSeen = 1'h1;
        dc(1);
        delimiterSeen = 1'h0;
        crcHold = viaError;
        dc(9);
        check(16'(link.rxBitClock), 16'h0);
        crcHold = 1'h0;
        n = 0;
        while (rxByteValid !== 1'h1 && n++ < 400) hc(1);
        guard(n > 400);
        check(16'(rxByte), 16'(b));
        headerError = viaError;
        rxEnable = viaError;
        dc(1);
        headerError = 1'h0;
        dc(8);
        check(16'({link.headerValidStrobe, frameActive}), 16'h0);
        rxEnable = 1'h0;
        dc(2);
    endtask
    initial begin
        hc(4);
        srst = 1'h0;
        hc(3);
        check(16'({link.antennaSelect, link.antennaSelectN, link.txReady,
            link.headerValidStrobe}), 16'h4);
        antennaSwitch = 1'h1;
        dc(1);
        antennaSwitch = 1'h0;
        dc(3);
        check(16'({link.antennaSelect, link.antennaSelectN}), 16'h2);
        for (int i = 0; i < 8; i++) begin
            ccaMode = cca_mode_t'(i);
            ccaInvert = i[2];
            dc(8);
            check(16'({link.channelClearFlag, channelBusy}),
                16'({~i[0] ^ i[2], ~i[0]}));
        end
        ccaInvert = 1'h0;
        txStart = 1'h1;
        hc(1);
        txStart = 1'h0;
        putByte(8'ha5, 1'h0);
        putByte(8'h5a, 1'h1);
        n = 0;
        while (txBusy !== 1'h0 && n++ < 3000) hc(1);
        guard(n > 3000);
        n = 0;
        while (txRunning === 1'h1 && n++ < 200) dc(1);
        check(16'(n >= RAMP_CYCLES && n <= RAMP_CYCLES + 5), 16'h1);
        check(txGot, 16'h5aa5);
        for (int r = 0; r < 4; r++) begin
            rxRate = rate_t'(r);
            getByte(8'(8'h3c + r * 8'h51), r[0]);
        end
        conclude();
    end
endmodule
